// >>> rtl/rcw_pkg.sv
// Constants and types for the reset cause and wake logic
package rcw_pkg;

    // Configuration word addresses, read by table access
    localparam logic [23:0] RCW_CFG_OSC_ADDR = 24'hf80000;
    localparam logic [23:0] RCW_CFG_WDT_ADDR = 24'hf80002;
    localparam logic [23:0] RCW_CFG_BP_ADDR = 24'hf80004;
    localparam logic [23:0] RCW_CFG_CS_ADDR = 24'hf8000a;
    localparam int RCW_CFG_WORD_W = 24;
    localparam int RCW_CFG_DATA_W = 16;
    localparam int RCW_CFG_COUNT = 4;
    localparam logic [15:0] RCW_CFG_RESET = 16'hffff;
    localparam logic [7:0] RCW_CFG_PAD = 8'h00;

    // Configuration fields
    localparam int RCW_CLKMON_EN_BIT = 14;
    localparam int RCW_WDT_EN_BIT = 15;

    // Reset cause register fields
    localparam int RCW_TRAP_BIT = 15;
    localparam int RCW_IOP_BIT = 14;
    localparam int RCW_EXT_BIT = 7;
    localparam int RCW_SW_BIT = 6;
    localparam int RCW_WDT_BIT = 4;
    localparam int RCW_SLEEP_BIT = 3;
    localparam int RCW_IDLE_BIT = 2;
    localparam int RCW_BROWNOUT_BIT = 1;
    localparam int RCW_POR_BIT = 0;
    localparam logic [15:0] RCW_CAUSE_RESET = 16'h0003;

    // Restart addresses
    localparam logic [23:0] RCW_RESET_VEC = 24'h000000;
    localparam logic [23:0] RCW_CLKFAIL_VEC = 24'h000004;

    typedef enum logic [1:0] {
        RCW_RUN = 2'b00,
        RCW_SLEEP = 2'b01,
        RCW_IDLE = 2'b10,
        RCW_OSC_WAIT = 2'b11
    } rcw_state_e;

    typedef enum logic [1:0] {
        RCW_POST_RESET = 2'b00,
        RCW_POST_RESUME = 2'b01,
        RCW_POST_VECTOR = 2'b10
    } rcw_post_e;

    typedef struct packed {
        logic por;
        logic brownout;
        logic pin_rst;
        logic sw_rst;
        logic wdt;
        logic trap;
        logic iop;
        logic irq;
    } rcw_evt_s;

    typedef struct packed {
        logic load;
        logic resume;
        logic [23:0] addr;
    } rcw_pc_s;

    typedef struct packed {
        rcw_state_e st;
        rcw_post_e post;
        logic [15:0] cause;
        logic [RCW_CFG_COUNT-1:0][RCW_CFG_DATA_W-1:0] cfg;
        logic [23:0] vec;
        rcw_pc_s pc;
        logic fast_rc_en;
        logic trap;
        logic tbl_ack;
        logic tbl_hit;
        logic [23:0] tbl_data;
    } rcw_st_s;

endpackage

// >>> rtl/rcw_reset_wake.sv
// Reset cause flags, power-save wake control and configuration words
`timescale 1ns/1ns
`default_nettype none

module rcw_reset_wake
    import rcw_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset, power-on
    input wire logic ce, // Clock enable
    input wire rcw_evt_s evt_i, // Event pulses
    input wire logic [23:0] irq_vector, // Vector of waking interrupt
    input wire logic psave_req, // Power save instruction executed
    input wire logic psave_idle, // 1 idle, 0 sleep
    input wire logic startup_done, // Start-up delays expired
    input wire logic osc_ok, // Crystal clock running
    input wire logic cause_wr, // Cause register write
    input wire logic [15:0] cause_wdata, // Cause write data
    output logic [15:0] cause_rdata, // Cause register contents
    input wire logic tbl_rd, // Table read strobe
    input wire logic [23:0] tbl_addr, // Table read address
    output logic tbl_ack, // Table read answer
    output logic tbl_hit, // Address names a word
    output logic [23:0] tbl_data, // Table read data
    input wire logic cfg_wr, // Programmer write strobe
    input wire logic [23:0] cfg_addr, // Programmer address
    input wire logic [15:0] cfg_wdata, // Programmer data
    output rcw_pc_s pc_o, // Program counter load
    output logic clk_fail_trap, // Clock failure trap pulse
    output logic cpu_clk_en, // Processor clock enable
    output logic cpu_stall, // Waiting for clock
    output logic osc_en, // Primary clock source enable
    output logic lp_rc_en, // Low-power RC enable
    output logic fast_rc_en // Fast RC enable
);

    rcw_st_s s_r;
    rcw_st_s s_nxt;

    logic rst_ext;
    logic wdt_on;
    logic clkmon_on;
    logic any_evt;

    // Map an address onto a configuration word: {hit, index}
    function automatic logic [2:0] cfg_decode(input logic [23:0] a);
        logic [2:0] r;
        r = 3'b000;
        if (a == RCW_CFG_OSC_ADDR) begin
            r = 3'b100;
        end else if (a == RCW_CFG_WDT_ADDR) begin
            r = 3'b101;
        end else if (a == RCW_CFG_BP_ADDR) begin
            r = 3'b110;
        end else if (a == RCW_CFG_CS_ADDR) begin
            r = 3'b111;
        end
        return r;
    endfunction

    assign rst_ext = evt_i.por | evt_i.brownout | evt_i.pin_rst;
    assign wdt_on = s_r.cfg[1][RCW_WDT_EN_BIT];
    assign clkmon_on = s_r.cfg[0][RCW_CLKMON_EN_BIT];
    assign any_evt = |evt_i;

    always_comb begin
        logic [15:0] set;
        logic [15:0] clr;
        logic [2:0] dec;
        logic rst_hit;
        set = 16'h0000;
        clr = 16'h0000;
        dec = 3'b000;
        rst_hit = 1'b0;
        s_nxt = s_r;
        s_nxt.pc.load = 1'b0;
        s_nxt.pc.resume = 1'b0;
        s_nxt.trap = 1'b0;
        s_nxt.tbl_ack = 1'b0;

        if (cause_wr) begin
            s_nxt.cause = cause_wdata;
        end

        if (evt_i.por) begin
            // Power-on clears every other cause except brownout, which it also sets
            clr = 16'hffff;
            set[RCW_POR_BIT] = 1'b1;
            set[RCW_BROWNOUT_BIT] = 1'b1;
            rst_hit = 1'b1;
        end else if (evt_i.brownout) begin
            set[RCW_BROWNOUT_BIT] = 1'b1;
            rst_hit = 1'b1;
        end else if (evt_i.pin_rst) begin
            set[RCW_EXT_BIT] = 1'b1;
            rst_hit = 1'b1;
        end else if (s_r.st == RCW_RUN) begin
            if (evt_i.sw_rst) begin
                set[RCW_SW_BIT] = 1'b1;
                rst_hit = 1'b1;
            end else if (evt_i.wdt && wdt_on) begin
                set[RCW_WDT_BIT] = 1'b1;
                rst_hit = 1'b1;
            end else if (evt_i.trap) begin
                set[RCW_TRAP_BIT] = 1'b1;
                rst_hit = 1'b1;
            end else if (evt_i.iop) begin
                set[RCW_IOP_BIT] = 1'b1;
                rst_hit = 1'b1;
            end
        end

        if (rst_hit) begin
            // Any non power-on reset records the power state it ended
            if (!evt_i.por && s_r.st == RCW_SLEEP) begin
                set[RCW_SLEEP_BIT] = 1'b1;
            end
            if (!evt_i.por && s_r.st == RCW_IDLE) begin
                set[RCW_IDLE_BIT] = 1'b1;
            end
            s_nxt.st = RCW_OSC_WAIT;
            s_nxt.post = RCW_POST_RESET;
            s_nxt.fast_rc_en = 1'b0;
        end else begin
            case (s_r.st)
                RCW_RUN: begin
                    if (psave_req) begin
                        s_nxt.st = psave_idle ? RCW_IDLE : RCW_SLEEP;
                    end
                end
                RCW_SLEEP: begin
                    if (evt_i.wdt && wdt_on) begin
                        set[RCW_SLEEP_BIT] = 1'b1;
                        set[RCW_WDT_BIT] = 1'b1;
                        s_nxt.st = RCW_OSC_WAIT;
                        s_nxt.post = RCW_POST_RESUME;
                    end else if (evt_i.irq) begin
                        set[RCW_SLEEP_BIT] = 1'b1;
                        s_nxt.vec = irq_vector;
                        s_nxt.st = RCW_OSC_WAIT;
                        s_nxt.post = RCW_POST_VECTOR;
                    end
                end
                RCW_IDLE: begin
                    // Clock source never stopped, so leave at once
                    if (evt_i.wdt && wdt_on) begin
                        set[RCW_IDLE_BIT] = 1'b1;
                        set[RCW_WDT_BIT] = 1'b1;
                        s_nxt.st = RCW_RUN;
                        s_nxt.pc.resume = 1'b1;
                    end else if (evt_i.irq) begin
                        set[RCW_IDLE_BIT] = 1'b1;
                        s_nxt.st = RCW_RUN;
                        s_nxt.pc.load = 1'b1;
                        s_nxt.pc.addr = irq_vector;
                    end
                end
                RCW_OSC_WAIT: begin
                    if (startup_done && osc_ok) begin
                        s_nxt.st = RCW_RUN;
                        case (s_r.post)
                            RCW_POST_RESUME: begin
                                s_nxt.pc.resume = 1'b1;
                            end
                            RCW_POST_VECTOR: begin
                                s_nxt.pc.load = 1'b1;
                                s_nxt.pc.addr = s_r.vec;
                            end
                            default: begin
                                s_nxt.pc.load = 1'b1;
                                s_nxt.pc.addr = RCW_RESET_VEC;
                            end
                        endcase
                    end else if (startup_done && clkmon_on) begin
                        // Dead crystal: run from fast RC and trap
                        s_nxt.st = RCW_RUN;
                        s_nxt.fast_rc_en = 1'b1;
                        s_nxt.trap = 1'b1;
                        s_nxt.pc.load = 1'b1;
                        s_nxt.pc.addr = RCW_CLKFAIL_VEC;
                    end
                end
                default: begin
                    s_nxt.st = RCW_OSC_WAIT;
                end
            endcase
        end

        // Events win over a software write in the same cycle
        s_nxt.cause = (s_nxt.cause & ~clr) | set;

        if (tbl_rd) begin
            dec = cfg_decode(tbl_addr);
            s_nxt.tbl_ack = 1'b1;
            s_nxt.tbl_hit = dec[2];
            s_nxt.tbl_data = 24'h000000;
            if (dec[2]) begin
                // Upper byte of each word reads as zero
                s_nxt.tbl_data = {RCW_CFG_PAD, s_r.cfg[dec[1:0]]};
            end
        end
        if (cfg_wr) begin
            dec = cfg_decode(cfg_addr);
            if (dec[2]) begin
                s_nxt.cfg[dec[1:0]] = cfg_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_r.st <= RCW_OSC_WAIT;
            s_r.post <= RCW_POST_RESET;
            s_r.cause <= RCW_CAUSE_RESET;
            s_r.cfg <= {RCW_CFG_COUNT{RCW_CFG_RESET}};
            s_r.vec <= RCW_RESET_VEC;
            s_r.pc <= '0;
            s_r.fast_rc_en <= 1'b0;
            s_r.trap <= 1'b0;
            s_r.tbl_ack <= 1'b0;
            s_r.tbl_hit <= 1'b0;
            s_r.tbl_data <= 24'h000000;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign cause_rdata = s_r.cause;
    assign tbl_ack = s_r.tbl_ack;
    assign tbl_hit = s_r.tbl_hit;
    assign tbl_data = s_r.tbl_data;
    assign pc_o = s_r.pc;
    assign clk_fail_trap = s_r.trap;
    assign cpu_clk_en = (s_r.st == RCW_RUN);
    assign cpu_stall = (s_r.st == RCW_OSC_WAIT);
    assign osc_en = (s_r.st != RCW_SLEEP);
    assign lp_rc_en = clkmon_on;
    assign fast_rc_en = s_r.fast_rc_en;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    pin_run_flags_a: assert property (
        ce && s_r.st == RCW_RUN && evt_i.pin_rst && !evt_i.por
        && !evt_i.brownout && !cause_wr
        |=> cause_rdata[RCW_EXT_BIT] && cpu_stall)
        else $error("master clear while running mishandled");

    // Sleep flag is left as software last wrote it
    sw_flag_a: assert property (
        ce && s_r.st == RCW_RUN && evt_i.sw_rst && !rst_ext && !cause_wr
        |=> cause_rdata[RCW_SW_BIT]
        && cause_rdata[RCW_SLEEP_BIT] == $past(cause_rdata[RCW_SLEEP_BIT]))
        else $error("software reset flag not set");

    pin_sleep_a: assert property (
        ce && s_r.st == RCW_SLEEP && evt_i.pin_rst && !evt_i.por
        && !evt_i.brownout
        |=> cause_rdata[RCW_EXT_BIT] && cause_rdata[RCW_SLEEP_BIT])
        else $error("master clear in sleep flags wrong");

    pin_idle_a: assert property (
        ce && s_r.st == RCW_IDLE && evt_i.pin_rst && !evt_i.por
        && !evt_i.brownout
        |=> cause_rdata[RCW_EXT_BIT] && cause_rdata[RCW_IDLE_BIT])
        else $error("master clear in idle flags wrong");

    sleep_irq_wake_a: assert property (
        ce && s_r.st == RCW_SLEEP && evt_i.irq && !rst_ext
        && !(evt_i.wdt && wdt_on)
        |=> cause_rdata[RCW_SLEEP_BIT] && s_r.post == RCW_POST_VECTOR
        && !pc_o.load)
        else $error("interrupt wake from sleep wrong");

    por_clears_a: assert property (
        ce && evt_i.por
        |=> cause_rdata[RCW_POR_BIT] && !cause_rdata[RCW_SLEEP_BIT]
        && !cause_rdata[RCW_IDLE_BIT] && cpu_stall)
        else $error("power-on reset did not clear state flags");

    wdt_sleep_a: assert property (
        ce && s_r.st == RCW_SLEEP && evt_i.wdt && wdt_on && !rst_ext
        |=> cause_rdata[RCW_SLEEP_BIT] && cause_rdata[RCW_WDT_BIT]
        && s_r.post == RCW_POST_RESUME)
        else $error("watchdog wake from sleep wrong");

    idle_irq_vec_a: assert property (
        ce && s_r.st == RCW_IDLE && evt_i.irq && !rst_ext
        && !(evt_i.wdt && wdt_on)
        |=> pc_o.load && pc_o.addr == $past(irq_vector)
        && cause_rdata[RCW_IDLE_BIT] && cpu_clk_en)
        else $error("interrupt wake from idle wrong");

    wdt_idle_a: assert property (
        ce && s_r.st == RCW_IDLE && evt_i.wdt && wdt_on && !rst_ext
        |=> pc_o.resume && cpu_clk_en && cause_rdata[RCW_IDLE_BIT]
        && cause_rdata[RCW_WDT_BIT])
        else $error("watchdog wake from idle wrong");

    clk_fail_a: assert property (
        ce && cpu_stall && startup_done && !osc_ok && clkmon_on && !any_evt
        |=> clk_fail_trap && fast_rc_en && pc_o.addr == RCW_CLKFAIL_VEC)
        else $error("clock failure trap not taken");

    clk_stall_a: assert property (
        ce && cpu_stall && !osc_ok && !clkmon_on && !any_evt
        |=> cpu_stall && !pc_o.load)
        else $error("stall without monitor not held");

    idle_gate_a: assert property (
        s_r.st == RCW_IDLE |-> !cpu_clk_en && osc_en)
        else $error("idle clock gating wrong");

    tbl_read_a: assert property (
        ce && tbl_rd |=> tbl_ack && tbl_data[23:16] == RCW_CFG_PAD)
        else $error("table read answer wrong");

    flags_hold_a: assert property (
        ce && !srst && !any_evt && !cause_wr |=> $stable(cause_rdata))
        else $error("cause flags changed without cause");

    sleep_wake_c: cover property (
        s_r.st == RCW_SLEEP ##1 cpu_stall ##[1:8] pc_o.load);
    idle_wdt_c: cover property (
        s_r.st == RCW_IDLE ##1 pc_o.resume);
    clk_fail_c: cover property (clk_fail_trap);
    pin_sleep_c: cover property (
        ce && s_r.st == RCW_SLEEP && evt_i.pin_rst);

endmodule // rcw_reset_wake

`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the reset cause and wake logic
`timescale 1ns/1ns
`default_nettype none

module tb;
    import rcw_pkg::*;

    localparam rcw_evt_s EV_POR = 8'h80;
    localparam rcw_evt_s EV_BRN = 8'h40;
    localparam rcw_evt_s EV_PIN = 8'h20;
    localparam rcw_evt_s EV_SW = 8'h10;
    localparam rcw_evt_s EV_WDT = 8'h08;
    localparam rcw_evt_s EV_TRAP = 8'h04;
    localparam rcw_evt_s EV_IOP = 8'h02;
    localparam rcw_evt_s EV_IRQ = 8'h01;
    localparam logic [23:0] VEC = 24'h000120;

    logic clk = 1'b0;
    logic srst = 1'b1;
    rcw_evt_s evt_i = '0;
    logic psave_req = 1'b0;
    logic psave_idle = 1'b0;
    logic startup_done = 1'b1;
    logic osc_ok = 1'b1;
    logic cause_wr = 1'b0;
    logic [15:0] cause_wdata = 16'h0000;
    logic tbl_rd = 1'b0;
    logic [23:0] tbl_addr = 24'h000000;
    logic cfg_wr = 1'b0;
    logic [23:0] cfg_addr = 24'h000000;
    logic [15:0] cfg_wdata = 16'h0000;
    logic [15:0] cause_rdata;
    logic tbl_ack, tbl_hit, clk_fail_trap, cpu_clk_en, cpu_stall;
    logic osc_en, lp_rc_en, fast_rc_en;
    logic [23:0] tbl_data;
    rcw_pc_s pc_o;
    int n_mismatch = 0;
    int num_checks = 0;

    always #4 clk = ~clk;

    rcw_reset_wake dut_u (
        .clk(clk), .srst(srst), .ce(1'b1), .evt_i(evt_i),
        .irq_vector(VEC), .psave_req(psave_req),
        .psave_idle(psave_idle), .startup_done(startup_done),
        .osc_ok(osc_ok), .cause_wr(cause_wr), .cause_wdata(cause_wdata),
        .cause_rdata(cause_rdata), .tbl_rd(tbl_rd), .tbl_addr(tbl_addr),
        .tbl_ack(tbl_ack), .tbl_hit(tbl_hit), .tbl_data(tbl_data),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .pc_o(pc_o), .clk_fail_trap(clk_fail_trap),
        .cpu_clk_en(cpu_clk_en), .cpu_stall(cpu_stall), .osc_en(osc_en),
        .lp_rc_en(lp_rc_en), .fast_rc_en(fast_rc_en)
    );

    function automatic logic [15:0] fl(input int b);
        return 16'h0001 << b;
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic write_cause(input logic [15:0] d);
        @(posedge clk);
        cause_wr <= 1'b1;
        cause_wdata <= d;
        @(posedge clk);
        cause_wr <= 1'b0;
    endtask

    task automatic cfg_write(input logic [23:0] addr, input logic [15:0] d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_addr <= addr;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask

    task automatic fire(input rcw_evt_s e);
        @(posedge clk);
        evt_i <= e;
        @(posedge clk);
        evt_i <= '0;
    endtask

    // Power save entry; clock source stays up only in idle
    task automatic enter(input logic idle);
        @(posedge clk);
        psave_req <= 1'b1;
        psave_idle <= idle;
        @(posedge clk);
        psave_req <= 1'b0;
        @(negedge clk);
        chk(cpu_clk_en, 0);
        chk(osc_en, idle);
        chk(lp_rc_en, 1);
    endtask

    task automatic wait_pc(output logic ld, output logic [23:0] a,
            output int n);
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            if (pc_o.load === 1'b1 || pc_o.resume === 1'b1) break;
        end
        chk(n < 40, 1);
        ld = pc_o.load;
        a = pc_o.addr;
    endtask

    task automatic tbl_check(input logic [23:0] addr, input logic hit,
            input logic [23:0] data);
        @(posedge clk);
        tbl_rd <= 1'b1;
        tbl_addr <= addr;
        @(posedge clk);
        tbl_rd <= 1'b0;
        @(negedge clk);
        chk(tbl_ack, 1);
        chk(tbl_hit, hit);
        chk(tbl_data, data);
    endtask

    // Bit 8 is plain storage; it must survive every event but power-on
    task automatic event_case(input int mode, input rcw_evt_s e,
            input logic [15:0] flags, input logic ld_exp,
            input logic [23:0] a_exp, output int n);
        logic ld;
        logic [23:0] a;
        write_cause(16'h0100);
        if (mode != 0) enter(mode == 2);
        fire(e);
        wait_pc(ld, a, n);
        chk(cause_rdata, flags | 16'h0100);
        chk(ld, ld_exp);
        if (ld_exp) chk(a, a_exp);
    endtask

    task automatic t_reset();
        logic ld;
        logic [23:0] a;
        int n;
        @(negedge clk);
        chk(cpu_stall, 1);
        chk(cause_rdata, RCW_CAUSE_RESET);
        wait_pc(ld, a, n);
        chk(a, RCW_RESET_VEC);
        write_cause(16'h5a5a);
        @(negedge clk);
        chk(cause_rdata, 16'h5a5a);
        tbl_check(RCW_CFG_OSC_ADDR, 1, 24'h00ffff);
        tbl_check(RCW_CFG_WDT_ADDR, 1, 24'h00ffff);
        tbl_check(RCW_CFG_BP_ADDR, 1, 24'h00ffff);
        tbl_check(RCW_CFG_CS_ADDR, 1, 24'h00ffff);
        tbl_check(24'hf80006, 0, 24'h000000);
        cfg_write(RCW_CFG_BP_ADDR, 16'h1234);
        tbl_check(RCW_CFG_BP_ADDR, 1, 24'h001234);
    endtask

    task automatic t_run();
        int n;
        event_case(0, EV_PIN, fl(RCW_EXT_BIT), 1, 0, n);
        event_case(0, EV_SW, fl(RCW_SW_BIT), 1, 0, n);
        event_case(0, EV_WDT, fl(RCW_WDT_BIT), 1, 0, n);
        event_case(0, EV_TRAP, fl(RCW_TRAP_BIT), 1, 0, n);
        event_case(0, EV_IOP, fl(RCW_IOP_BIT), 1, 0, n);
        event_case(0, EV_BRN, fl(RCW_BROWNOUT_BIT), 1, 0, n);
    endtask

    task automatic t_sleep();
        int n;
        logic [15:0] s;
        s = fl(RCW_SLEEP_BIT);
        event_case(1, EV_PIN, s | fl(RCW_EXT_BIT), 1, 0, n);
        event_case(1, EV_BRN, s | fl(RCW_BROWNOUT_BIT), 1, 0, n);
        event_case(1, EV_IRQ, s, 1, VEC, n);
        event_case(1, EV_WDT, s | fl(RCW_WDT_BIT), 0, 0, n);
    endtask

    task automatic t_idle();
        int n;
        logic [15:0] s;
        s = fl(RCW_IDLE_BIT);
        event_case(2, EV_PIN, s | fl(RCW_EXT_BIT), 1, 0, n);
        event_case(2, EV_BRN, s | fl(RCW_BROWNOUT_BIT), 1, 0, n);
        event_case(2, EV_IRQ, s, 1, VEC, n);
        chk(n < 2, 1);
        chk(cpu_clk_en, 1);
        event_case(2, EV_WDT, s | fl(RCW_WDT_BIT), 0, 0, n);
        chk(n < 2, 1);
    endtask

    task automatic t_clock_fail();
        int n;
        logic ld;
        logic [23:0] a;
        @(posedge clk);
        osc_ok <= 1'b0;
        event_case(0, EV_PIN, fl(RCW_EXT_BIT), 1,
            RCW_CLKFAIL_VEC, n);
        chk(clk_fail_trap, 1);
        chk(fast_rc_en, 1);
        cfg_write(RCW_CFG_OSC_ADDR, 16'hbfff);
        @(negedge clk);
        chk(lp_rc_en, 0);
        fire(EV_PIN);
        // Monitor off: the core must simply wait for the crystal
        repeat (10) begin
            @(negedge clk);
            chk({cpu_stall, pc_o.load, clk_fail_trap}, 3'b100);
        end
        @(posedge clk);
        osc_ok <= 1'b1;
        wait_pc(ld, a, n);
        chk(a, RCW_RESET_VEC);
        cfg_write(RCW_CFG_OSC_ADDR, 16'hffff);
    endtask

    task automatic t_por();
        int n;
        logic ld;
        logic [23:0] a;
        enter(1'b0);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        wait_pc(ld, a, n);
        chk(cause_rdata, RCW_CAUSE_RESET);
        chk(fast_rc_en, 0);
        // A power-on event in idle wipes every flag but power-on and brownout, storage bits too
        write_cause(16'hffff);
        enter(1'b1);
        fire(EV_POR);
        wait_pc(ld, a, n);
        chk(cause_rdata, RCW_CAUSE_RESET);
        chk(a, RCW_RESET_VEC);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_run();
        t_sleep();
        t_idle();
        t_clock_fail();
        t_por();
        final_report();
    end

    // Whole run needs well under a few thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end

endmodule // tb

`default_nettype wire
